//--- rpr_defs.svh
// Constants of the rolling pixel readout formatter: offsets, fields, resets, timing.
// Included by its bare name; holds definitions only.
`ifndef RPR_DEFS_SVH
`define RPR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RPR_REG_CTRL    8'h00
`define RPR_REG_MODE    8'h04
`define RPR_REG_EXPO    8'h08
`define RPR_REG_DGAIN   8'h0C
`define RPR_CGAIN_PAGE  4'h1
`define RPR_REG_LANES   8'h20
`define RPR_REG_STATUS  8'h24

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define RPR_CTRL_RUN    0
`define RPR_CTRL_MIRROR 1
`define RPR_CTRL_FLASH  2
`define RPR_CTRL_RST    3'h2
`define RPR_EXPO_RST    12'h010
`define RPR_GAIN_RST    8'h40
`define RPR_LANES_RST   3'h4
`define RPR_LANES_MIN   3'h2

// ----------------------------------------------------------------
// Array geometry and pipeline
// ----------------------------------------------------------------
`define RPR_PHYS_COLS   3280
`define RPR_PHYS_ROWS   2464
`define RPR_ACT_COLS    3264
`define RPR_ACT_ROWS    2448
`define RPR_PATHS       4
`define RPR_ACT_ROW0    ((`RPR_PHYS_ROWS - `RPR_ACT_ROWS) / 2)
`define RPR_ACT_GRP0    (((`RPR_PHYS_COLS - `RPR_ACT_COLS) / 2) / `RPR_PATHS)
`define RPR_IN_GRPS     (`RPR_ACT_COLS / `RPR_PATHS)
`define RPR_GAIN_SHIFT  12
`define RPR_BLK_SHIFT   3
`define RPR_WORD_BITS   6'd40

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RPR_CLK_NS      25
`define RPR_ROW_TIME_NS 26000
`define RPR_ROW_CYC     ((`RPR_ROW_TIME_NS + `RPR_CLK_NS - 1) / `RPR_CLK_NS)

// ----------------------------------------------------------------
// Mode table: window rows, row offset, output groups, output row pairs
// ----------------------------------------------------------------
`define RPR_M_FULL43  {12'd2448, 12'd0, 10'd816, 11'd1224}
`define RPR_M_FULL169 {12'd1836, 12'd306, 10'd816, 11'd918}
`define RPR_M_VGA     {12'd2448, 12'd0, 10'd160, 11'd240}
`define RPR_M_HD1080  {12'd1836, 12'd306, 10'd480, 11'd540}
`define RPR_M_HD1080S {12'd1836, 12'd306, 10'd576, 11'd648}
`define RPR_M_HD720   {12'd1836, 12'd306, 10'd320, 11'd360}
`define RPR_M_HD720S  {12'd1836, 12'd306, 10'd384, 11'd432}

`endif

//--- rpr_pkg.sv
// Types of the rolling pixel readout formatter.
// Constants live in rpr_defs.svh.
package rpr_pkg;

  typedef enum logic [2:0] {
    MODE_FULL43, MODE_FULL169, MODE_VGA, MODE_HD1080,
    MODE_HD1080_STAB, MODE_HD720, MODE_HD720_STAB
  } rpr_mode_e;

  typedef enum logic [2:0] {S_IDLE, S_ROW, S_REQ, S_WAIT, S_LOAD} rpr_fsm_e;

  typedef logic [9:0] rpr_sample_t;

  typedef struct packed {
    rpr_sample_t [3:0] lane;
  } rpr_quad_s;

  typedef struct packed {
    logic [11:0] win_rows;
    logic [11:0] row_off;
    logic [9:0]  out_grps;
    logic [10:0] out_pairs;
  } rpr_cfg_s;

  typedef struct packed {
    rpr_fsm_e              st;
    logic [2:0]            ctrl;
    logic [2:0]            ctrl_sh;
    rpr_mode_e             mode;
    rpr_mode_e             mode_sh;
    logic [11:0]           expo;
    logic [11:0]           expo_sh;
    logic [2:0]            lanes;
    logic [2:0]            lanes_sh;
    logic [7:0]            dgain;
    logic [3:0][7:0]       cgain;
    logic [3:0][9:0]       offs;
    logic [12:0]           seq;
    logic [12:0]           ridx;
    logic [15:0]           timer;
    logic [9:0]            col;
    logic [9:0]            hacc;
    logic [10:0]           vacc;
    logic                  vkeep;
    logic                  dark;
    logic                  rpar;
    logic [39:0]           word;
    logic [39:0]           sh;
    logic [5:0]            bits;
    logic [2:0]            lk;
    logic [7:0]            frames;
    logic                  row_rst_stb;
    logic [11:0]           row_rst_addr;
    logic                  row_rd_stb;
    logic [11:0]           row_rd_addr;
    logic                  adc_req;
    logic [9:0]            adc_grp;
    logic [3:0]            lane_data;
    logic [3:0]            lane_en;
    logic                  line_valid;
    logic                  frame_valid;
    logic                  flash;
    logic [31:0]           rdata;
  } rpr_state_s;

endpackage : rpr_pkg

//--- rpr_pixel_path.sv
// One column data path: black-level subtraction, colour gain, digital gain.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "rpr_defs.svh"

module rpr_pixel_path (
  // Sample and its correction settings
  input  wire logic [9:0] i_sample,
  input  wire logic [9:0] i_offset,
  input  wire logic [7:0] i_cgain,
  input  wire logic [7:0] i_dgain,
  // Corrected pixel and tracked black level
  output logic      [9:0] o_pixel,
  output logic      [9:0] o_offset_next
);

  logic [9:0]  diff;
  logic [25:0] prod;
  logic [25:0] scaled;

  always_comb begin
    diff   = (i_sample > i_offset) ? i_sample - i_offset : 10'h000;
    prod   = 26'(diff) * 26'(i_cgain) * 26'(i_dgain);
    scaled = prod >> `RPR_GAIN_SHIFT;
    // Saturate rather than wrap, so bright pixels stay bright.
    o_pixel = (|scaled[25:10]) ? 10'h3FF : scaled[9:0];
    // The black level follows dark samples slowly to ride out noise.
    if (i_sample >= i_offset) begin
      o_offset_next = i_offset + ((i_sample - i_offset) >> `RPR_BLK_SHIFT);
    end else begin
      o_offset_next = i_offset - ((i_offset - i_sample) >> `RPR_BLK_SHIFT);
    end
  end

endmodule : rpr_pixel_path

//--- rpr_top.sv
// Row sequencer, pixel formatter and lane serializer of a Bayer image sensor.
// Assumes converter data on i_clk and a free-running link clock from outside.
//
// What this block does
// - Reset then read each row in turn.
// - Exposure equals programmed row times reset to read.
// - One 10-bit sample per pixel read.
// - Apply corrections and digital gain before output.
// - Dark pixels set subtracted black offset.
// - Even rows green/red, odd rows blue/green.
// - Even columns red/green, odd columns blue/green.
// - Mirroring on after reset, left to right.
// - Active 3264x2448 inside 3280x2464 array.
// - Two, three or four serial lanes only.
// - Full 4:3 mode outputs 3264x2448 unscaled.
// - Full 16:9 mode outputs 3264x1836 unscaled.
// - Video modes scale to smaller outputs.
// - Margin modes output 2304x1296 or 1536x864.
// - Full modes carry 732 Mbps per lane; here one bit per lane per sampled link edge, at most every second i_clk.
// - Offset and gain per colour channel.
// - Frame size, exposure, gain set by registers.
// - Flash output marks the exposure period.
// - Four pixel streams processed in parallel.
// - Registers reached over controller-driven serial access.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "rpr_defs.svh"

module rpr_top #(
  parameter int unsigned ROW_CYC = `RPR_ROW_CYC
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  // Register port
  input  wire logic [7:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [31:0]         o_rdata,
  // Column converters
  input  wire logic                i_adc_valid,
  input  wire rpr_pkg::rpr_quad_s  i_adc_data,
  output logic                     o_adc_req,
  output logic      [9:0]          o_adc_grp,
  // Row sequencing
  output logic                     o_row_rst_stb,
  output logic      [11:0]         o_row_rst_addr,
  output logic                     o_row_rd_stb,
  output logic      [11:0]         o_row_rd_addr,
  // Serial lanes
  input  wire logic                i_link_clk,
  output logic      [3:0]          o_lane_data,
  output logic      [3:0]          o_lane_en,
  output logic                     o_line_valid,
  output logic                     o_frame_valid,
  // Flash
  output logic                     o_flash
);

  // ----------------------------------------------------------------
  // Constants and checks
  // ----------------------------------------------------------------
  localparam int          PATHS   = `RPR_PATHS;
  localparam logic [12:0] DARK    = 13'(`RPR_ACT_ROW0);
  localparam logic [11:0] ROW0    = 12'(`RPR_ACT_ROW0);
  localparam logic [9:0]  GRP0    = 10'(`RPR_ACT_GRP0);
  localparam logic [10:0] IN_GRPS = 11'(`RPR_IN_GRPS);
  localparam logic [9:0]  LAST    = 10'(`RPR_IN_GRPS - 1);

  if (ROW_CYC < 1 || ROW_CYC > 65536) begin : g_bad_row_cyc
    $error("ROW_CYC must lie in 1..65536");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Window and output size of each mode.
  function automatic rpr_pkg::rpr_cfg_s cfg_of(input rpr_pkg::rpr_mode_e m);
    case (m)
      rpr_pkg::MODE_FULL169:     return `RPR_M_FULL169;
      rpr_pkg::MODE_VGA:         return `RPR_M_VGA;
      rpr_pkg::MODE_HD1080:      return `RPR_M_HD1080;
      rpr_pkg::MODE_HD1080_STAB: return `RPR_M_HD1080S;
      rpr_pkg::MODE_HD720:       return `RPR_M_HD720;
      rpr_pkg::MODE_HD720_STAB:  return `RPR_M_HD720S;
      default:                   return `RPR_M_FULL43;
    endcase
  endfunction : cfg_of

  // Dark rows sit in the top border; active rows are centred in the array.
  function automatic logic [11:0] phys_row(input logic [12:0] idx, input rpr_pkg::rpr_cfg_s c);
    if (idx < DARK) return idx[11:0];
    return ROW0 + c.row_off + 12'(idx - DARK);
  endfunction : phys_row

  function automatic logic [3:0] lane_mask(input logic [2:0] n);
    case (n)
      3'h2:    return 4'h3;
      3'h3:    return 4'h7;
      default: return 4'hF;
    endcase
  endfunction : lane_mask

  // ----------------------------------------------------------------
  // State and column data paths
  // ----------------------------------------------------------------
  rpr_pkg::rpr_state_s q;
  rpr_pkg::rpr_state_s d;
  rpr_pkg::rpr_cfg_s   cfg_c;
  rpr_pkg::rpr_cfg_s   cfg_n;
  logic [9:0]          samp [PATHS];
  logic [9:0]          pix  [PATHS];
  logic [9:0]          offn [PATHS];
  logic [1:0]          chan [PATHS];
  logic                step;
  logic                fs;
  logic                adv;
  logic                hkeep;
  logic                vk;
  logic                edge_l;
  logic [12:0]         nseq;
  logic [12:0]         ridx;
  logic [12:0]         nrows_c;
  logic [12:0]         nrows_n;
  logic [12:0]         flen;
  logic [11:0]         expo_n;
  logic [10:0]         hsum;
  logic [11:0]         vsum;
  logic [11:0]         vin;
  logic [2:0]          nl;

  for (genvar i = 0; i < PATHS; i++) begin : g_path
    localparam bit CP = (i % 2) == 1;
    // Mirror off reverses the column order within a group too.
    assign samp[i] = q.ctrl_sh[`RPR_CTRL_MIRROR] ? i_adc_data.lane[i] : i_adc_data.lane[PATHS-1-i];
    // Channel index {row parity, column parity}: 0 red, 1 green, 2 green, 3 blue.
    assign chan[i] = {q.rpar, CP ^ ~q.ctrl_sh[`RPR_CTRL_MIRROR]};
    rpr_pixel_path u_path (
      .i_sample      (samp[i]),
      .i_offset      (q.offs[chan[i]]),
      .i_cgain       (q.cgain[chan[i]]),
      .i_dgain       (q.dgain),
      .o_pixel       (pix[i]),
      .o_offset_next (offn[i])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    step    = 1'b0;
    fs      = 1'b0;
    adv     = 1'b0;
    hkeep   = 1'b0;
    vk      = q.vkeep;
    nseq    = q.seq;
    ridx    = 13'h0000;
    hsum    = 11'h000;
    vsum    = 12'h000;
    cfg_c   = cfg_of(q.mode_sh);
    nrows_c = DARK + {1'b0, cfg_c.win_rows};
    flen    = nrows_c + {1'b0, q.expo_sh};
    nl      = q.lanes_sh;
    edge_l  = q.lk[1] & ~q.lk[2];
    d.lk          = {q.lk[1:0], i_link_clk};
    d.row_rst_stb = 1'b0;
    d.row_rd_stb  = 1'b0;
    d.adc_req     = 1'b0;
    d.rdata       = 32'h0000_0000;
    if (q.timer != 16'h0000) d.timer = q.timer - 16'h0001;

    // Register writes and reads; illegal mode or lane codes are ignored.
    if (i_wr) begin
      if (i_addr == `RPR_REG_CTRL) d.ctrl = i_wdata[2:0];
      if (i_addr == `RPR_REG_MODE && i_wdata[2:0] <= rpr_pkg::MODE_HD720_STAB) begin
        d.mode = rpr_pkg::rpr_mode_e'(i_wdata[2:0]);
      end
      if (i_addr == `RPR_REG_EXPO) d.expo = i_wdata[11:0];
      if (i_addr == `RPR_REG_DGAIN) d.dgain = i_wdata[7:0];
      if (i_addr[7:4] == `RPR_CGAIN_PAGE && i_addr[1:0] == 2'b00) d.cgain[i_addr[3:2]] = i_wdata[7:0];
      if (i_addr == `RPR_REG_LANES && i_wdata[2:0] >= `RPR_LANES_MIN && i_wdata[2:0] <= `RPR_LANES_RST) begin
        d.lanes = i_wdata[2:0];
      end
    end
    if (i_rd) begin
      if (i_addr[7:4] == `RPR_CGAIN_PAGE && i_addr[1:0] == 2'b00) begin
        d.rdata = {24'h000000, q.cgain[i_addr[3:2]]};
      end
      case (i_addr)
        `RPR_REG_CTRL:   d.rdata = {29'h0, q.ctrl};
        `RPR_REG_MODE:   d.rdata = {29'h0, q.mode};
        `RPR_REG_EXPO:   d.rdata = {20'h0, q.expo};
        `RPR_REG_DGAIN:  d.rdata = {24'h0, q.dgain};
        `RPR_REG_LANES:  d.rdata = {29'h0, q.lanes};
        `RPR_REG_STATUS: d.rdata = {16'h0, q.frames, 5'h0, q.line_valid, q.flash, q.frame_valid};
        default:         ;
      endcase
    end

    // Row sequencer and column fetch.
    unique case (q.st)
      rpr_pkg::S_IDLE: begin
        if (q.ctrl[`RPR_CTRL_RUN]) begin
          fs   = 1'b1;
          step = 1'b1;
          nseq = 13'h0000;
        end
      end
      rpr_pkg::S_ROW: begin
        // A row time ends only after its readout has drained.
        if (q.timer == 16'h0000) begin
          step = 1'b1;
          if (q.seq == flen - 13'h0001) begin
            fs   = 1'b1;
            nseq = 13'h0000;
          end else begin
            nseq = q.seq + 13'h0001;
          end
        end
      end
      rpr_pkg::S_REQ: begin
        d.adc_req = 1'b1;
        d.adc_grp = q.ctrl_sh[`RPR_CTRL_MIRROR] ? GRP0 + q.col : GRP0 + LAST - q.col;
        d.st      = rpr_pkg::S_WAIT;
      end
      rpr_pkg::S_WAIT: begin
        if (i_adc_valid) begin
          // Horizontal Bayer-domain decimation by a ratio accumulator.
          hsum   = {1'b0, q.hacc} + {1'b0, cfg_c.out_grps};
          hkeep  = hsum >= IN_GRPS;
          d.hacc = hkeep ? 10'(hsum - IN_GRPS) : hsum[9:0];
          if (q.dark) begin
            for (int i = 0; i < 2; i++) d.offs[chan[i]] = offn[i];
          end
          if (!q.dark && q.vkeep && hkeep) begin
            d.word = {pix[3], pix[2], pix[1], pix[0]};
            d.st   = rpr_pkg::S_LOAD;
          end else begin
            adv = 1'b1;
          end
        end
      end
      rpr_pkg::S_LOAD: begin
        // The fetch stalls here while the serializer still holds a word.
        if (q.bits == 6'h00) begin
          d.sh   = q.word;
          d.bits = `RPR_WORD_BITS;
          adv    = 1'b1;
        end
      end
    endcase

    if (adv) begin
      if (q.col == LAST) begin
        d.st = rpr_pkg::S_ROW;
      end else begin
        d.col = q.col + 10'h001;
        d.st  = rpr_pkg::S_REQ;
      end
    end

    // Settings that shape a frame are taken only when a frame starts.
    // A stop keeps the old shadows, so they never move without a new frame.
    if (fs && q.ctrl[`RPR_CTRL_RUN]) begin
      d.mode_sh  = q.mode;
      d.expo_sh  = q.expo;
      d.lanes_sh = q.lanes;
      d.ctrl_sh  = q.ctrl;
      d.frames   = q.frames + 8'h01;
    end else if (fs) begin
      step = 1'b0;
      d.st = rpr_pkg::S_IDLE;
    end
    cfg_n   = cfg_of(fs ? q.mode : q.mode_sh);
    expo_n  = fs ? q.expo : q.expo_sh;
    nrows_n = DARK + {1'b0, cfg_n.win_rows};
    vin     = {1'b0, cfg_n.win_rows[11:1]};

    if (step) begin
      d.seq        = nseq;
      d.timer      = 16'(ROW_CYC - 1);
      d.col        = 10'h000;
      d.hacc       = 10'h000;
      d.line_valid = 1'b0;
      d.st         = rpr_pkg::S_ROW;
      // The reset front runs exposure rows ahead of the read front.
      if (nseq < nrows_n) begin
        d.row_rst_stb  = 1'b1;
        d.row_rst_addr = phys_row(nseq, cfg_n);
      end
      if (nseq >= {1'b0, expo_n}) begin
        ridx = nseq - {1'b0, expo_n};
        if (ridx < nrows_n) begin
          d.row_rd_stb  = 1'b1;
          d.row_rd_addr = phys_row(ridx, cfg_n);
          d.ridx        = ridx;
          d.dark        = ridx < DARK;
          d.rpar        = ridx[0];
          d.st          = rpr_pkg::S_REQ;
          // Rows are kept or dropped in pairs so the mosaic survives scaling.
          // Pair parity is taken against the first active row, not the array edge.
          if (!d.dark && ridx[0] == DARK[0]) begin
            vsum = {1'b0, fs ? 11'h000 : q.vacc} + {1'b0, cfg_n.out_pairs};
            vk   = vsum >= vin;
            d.vacc  = vk ? 11'(vsum - vin) : vsum[10:0];
            d.vkeep = vk;
          end
          d.line_valid = !d.dark && vk;
        end
      end
      if (fs) d.vacc = (ridx < nrows_n && nseq >= {1'b0, expo_n}) ? d.vacc : 11'h000;
    end

    d.frame_valid = d.st != rpr_pkg::S_IDLE;
    d.flash       = d.ctrl_sh[`RPR_CTRL_FLASH] && d.frame_valid && d.seq >= DARK;

    // One bit per active lane on each sampled link edge; the link clock sets the lane rate.
    if (edge_l) begin
      if (q.bits != 6'h00) begin
        d.lane_en   = lane_mask(nl);
        d.lane_data = q.sh[3:0] & lane_mask(nl);
        d.sh        = q.sh >> nl;
        d.bits      = (q.bits > {3'h0, nl}) ? q.bits - {3'h0, nl} : 6'h00;
      end else begin
        d.lane_en   = 4'h0;
        d.lane_data = 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q          <= '0;
      q.ctrl     <= `RPR_CTRL_RST;
      q.ctrl_sh  <= `RPR_CTRL_RST;
      q.expo     <= `RPR_EXPO_RST;
      q.expo_sh  <= `RPR_EXPO_RST;
      q.lanes    <= `RPR_LANES_RST;
      q.lanes_sh <= `RPR_LANES_RST;
      q.dgain    <= `RPR_GAIN_RST;
      q.cgain    <= {4{`RPR_GAIN_RST}};
    end else begin
      q <= d;
    end
  end

  assign o_rdata        = q.rdata;
  assign o_adc_req      = q.adc_req;
  assign o_adc_grp      = q.adc_grp;
  assign o_row_rst_stb  = q.row_rst_stb;
  assign o_row_rst_addr = q.row_rst_addr;
  assign o_row_rd_stb   = q.row_rd_stb;
  assign o_row_rd_addr  = q.row_rd_addr;
  assign o_lane_data    = q.lane_data;
  assign o_lane_en      = q.lane_en;
  assign o_line_valid   = q.line_valid;
  assign o_frame_valid  = q.frame_valid;
  assign o_flash        = q.flash;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_link_edge;
    q.lk[1] && !q.lk[2];
  endsequence

  sequence s_shift;
    s_link_edge ##0 (q.bits != 6'h00);
  endsequence

  a_row_step_order: assert property (
    $changed(q.seq) |-> q.seq == 13'h0000 || q.seq == $past(q.seq) + 13'h0001)
    else $error("row sequence skipped a row");
  a_row_time_gap: assert property (
    $changed(q.seq) |-> $past(q.timer) == 16'h0000 || $past(q.st) == rpr_pkg::S_IDLE)
    else $error("row step before row time elapsed");
  a_expo_gap: assert property (
    o_row_rd_stb |-> q.ridx == q.seq - {1'b0, q.expo_sh})
    else $error("read row not exposure rows behind");
  a_dark_no_out: assert property (
    (q.dark && q.st == rpr_pkg::S_WAIT) |=> q.st != rpr_pkg::S_LOAD)
    else $error("dark row sample reached the output");
  a_zero_gain: assert property (
    (q.st == rpr_pkg::S_WAIT && i_adc_valid && q.dgain == 8'h00) |=> q.st != rpr_pkg::S_LOAD || q.word == 40'h0)
    else $error("zero gain gave non-zero pixels");
  a_lane_count: assert property (
    s_shift |=> o_lane_en == lane_mask($past(q.lanes_sh)))
    else $error("wrong lane count driven");
  a_frame_shadow: assert property (
    $changed(q.mode_sh) |-> q.seq == 13'h0000 && $past(q.st) inside {rpr_pkg::S_IDLE, rpr_pkg::S_ROW})
    else $error("mode changed inside a frame");
  a_flash_expo: assert property (
    o_flash |-> o_frame_valid && q.seq >= DARK)
    else $error("flash outside the exposure period");
  a_rdata_window: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule : rpr_top

//--- rpr_adc_model.sv
// Column converter model: answers each group request with four samples.
// Assumes group requests from rpr_top on the same clock.
`timescale 1ns/1ps

module rpr_adc_model (
  // Clock and request
  input  wire logic          i_clk,
  input  wire logic          i_req,
  input  wire logic [9:0]    i_grp,
  // Answer
  output logic               o_valid,
  output rpr_pkg::rpr_quad_s o_data
);
  logic [1:0] wait_q = 2'h0;
  logic [9:0] grp_q  = 10'h000;
  logic [9:0] junk_q = 10'h000;

  // Outside an answer the data lines toggle, so stale samples never look valid.
  always @(posedge i_clk) begin
    junk_q  <= junk_q + 10'h00B;
    o_valid <= 1'b0;
    o_data  <= {4{~junk_q}};
    if (i_req) begin
      grp_q  <= i_grp;
      wait_q <= (i_grp[2:0] == 3'h0) ? 2'h3 : 2'h1;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h1) begin
        o_valid <= 1'b1;
        o_data  <= {4{grp_q}};
      end
    end
  end
endmodule : rpr_adc_model

//--- rpr_top_tb_top.sv
// Testbench of rpr_top: register map checks, then the start of one frame.
// Assumes rpr_adc_model as converter and a shortened row time.
`timescale 1ns/1ps

module rpr_top_tb_top;
  logic               i_clk      = 1'b0;
  logic               i_resetn   = 1'b0;
  logic               i_link_clk = 1'b0;
  logic [7:0]         i_addr     = 8'h00;
  logic [31:0]        i_wdata    = 32'h0;
  logic               i_wr       = 1'b0;
  logic               i_rd       = 1'b0;
  logic [31:0]        rdata;
  logic               adc_valid, adc_req, rst_stb, rd_stb, line_v, frame_v, flash;
  rpr_pkg::rpr_quad_s adc_data;
  logic [9:0]         adc_grp;
  logic [11:0]        rst_addr, rd_addr;
  logic [3:0]         lane_data, lane_en;
  int                 error_cnt  = 0;
  int                 num_checks = 0;
  localparam logic [7:0]  RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h30};
  localparam logic [31:0] RV [7] = '{32'h2, 32'h0, 32'h10, 32'h40, 32'h40, 32'h4, 32'h0};

  rpr_top #(.ROW_CYC(8)) dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .i_adc_valid(adc_valid), .i_adc_data(adc_data),
    .o_adc_req(adc_req), .o_adc_grp(adc_grp), .o_row_rst_stb(rst_stb), .o_row_rst_addr(rst_addr),
    .o_row_rd_stb(rd_stb), .o_row_rd_addr(rd_addr), .i_link_clk(i_link_clk),
    .o_lane_data(lane_data), .o_lane_en(lane_en), .o_line_valid(line_v),
    .o_frame_valid(frame_v), .o_flash(flash));

  rpr_adc_model adc (.i_clk(i_clk), .i_req(adc_req), .i_grp(adc_grp), .o_valid(adc_valid),
    .o_data(adc_data));

  initial forever #12.5 i_clk = ~i_clk;
  initial forever #100 i_link_clk = ~i_link_clk;

  task automatic tally_and_finish;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    v = rdata;
  endtask : rd

  // Bounded wait on a row reset strobe, or on the first group request.
  task automatic wait_for(input int which);
    int n;
    for (n = 0; n < 20000 && ((which == 0) ? rst_stb : adc_req) !== 1'b1; n++) @(negedge i_clk);
    if (n == 20000) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : wait_for

  initial begin
    logic [31:0] v;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(RA[i], v);
      chk(v, RV[i]);
    end
    wr(8'h04, 32'h7);
    wr(8'h20, 32'h1);
    rd(8'h04, v);
    chk(v, 32'h0);
    rd(8'h20, v);
    chk(v, 32'h4);
    wr(8'h20, 32'h2);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h3);
    rd(8'h20, v);
    chk(v, 32'h2);
    wr(8'h00, 32'h7);
    // Rows 0..7 are dark; the 16:9 window starts 306 rows further down.
    for (int k = 0; k < 12; k++) begin
      wait_for(0);
      chk(rst_addr, (k < 8) ? k : k + 306);
      chk(rd_stb, k >= 3);
      if (k >= 3) chk(rd_addr, (k < 11) ? k - 3 : 314);
      if (k < 8) chk(flash, 1'b0);
      chk(line_v, k == 11);
      chk(frame_v, 1'b1);
      if (k == 3) begin
        wait_for(1);
        chk(adc_grp, 10'd2);
      end
      @(negedge i_clk);
    end
    chk(flash, 1'b1);
    for (int n = 0; n < 20000 && lane_en == 4'h0; n++) @(negedge i_clk);
    chk(lane_en, 4'h3);
    // Converter samples sit far below the tracked dark level, so they clamp to zero.
    chk(lane_data, 4'h0);
    rd(8'h24, v);
    chk(v[2:0], 3'h7);
    wr(8'h0C, 32'h0);
    rd(8'h0C, v);
    chk(v, 32'h0);
    repeat (400) @(posedge i_clk);
    chk(lane_data, 4'h0);
    chk(lane_en, 4'h3);
    tally_and_finish();
  end
endmodule : rpr_top_tb_top
